// >>> udq_defines.svh
// udq_defines.svh: named constants for the ultra dma cable qualification block.
// assumes a 25 MHz core clock; included by its bare name.
`ifndef UDQ_DEFINES_SVH
`define UDQ_DEFINES_SVH
`define UDQ_CLK_PERIOD_NS 40
`define UDQ_SETTLE_NS 1000
`define UDQ_SETTLE_CYC ((`UDQ_SETTLE_NS + `UDQ_CLK_PERIOD_NS - 1) / `UDQ_CLK_PERIOD_NS)
`define UDQ_MODE_SLOW_MAX 3'h2
`define UDQ_MODE_FAST_MAX 3'h4
`define UDQ_SLACK_SLOW 3'h2
`define UDQ_SLACK_FAST 3'h3
`define UDQ_CYC_M0 8'hEB
`define UDQ_CYC_M1 8'hA0
`define UDQ_CYC_M2 8'h78
`define UDQ_CYC_M3 8'h5A
`define UDQ_CYC_M4 8'h3C
`endif

// >>> udq_pkg.sv
// udq_pkg.sv: types shared by the cable qualification block.
// assumes udq_defines.svh is on the include path.
package udq_pkg;
  typedef enum logic [1:0] {
    UDQ_IDLE = 2'h0,
    UDQ_SETTLE = 2'h1,
    UDQ_DONE = 2'h3
  } udq_state_t;

  typedef struct packed {
    logic cable_known;
    logic cable80;
    logic [2:0] mode;
    logic [7:0] cycle_ns;
  } udq_status_t;
endpackage : udq_pkg

// >>> udq_cable_qual.sv
// udq_cable_qual.sv: host cable check, mode limit and receive skid buffer.
// assumes word strobes are already decoded into clk-domain valid pulses;
// the cable-identify pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "udq_defines.svh"

module udq_cable_qual #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int SETTLE_CYC = `UDQ_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cblid_pin,
  input wire logic detect_start,
  input wire logic use_identify,
  input wire logic identify_valid,
  input wire logic identify_cable80,
  input wire logic [2:0] mode_req,
  output udq_pkg::udq_status_t status,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic dmardy,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  import udq_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int TW = $clog2(SETTLE_CYC + 1);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 4");
  end
  if (SETTLE_CYC < 1 || WIDTH < 1) begin : g_bad_size
    $error("SETTLE_CYC and WIDTH must be positive");
  end

  logic cblid_meta_reg;
  logic cblid_sync_reg;
  udq_state_t state_reg;
  logic [TW-1:0] timer_reg;
  logic [TW-1:0] settle_len_reg;
  logic known_reg;
  logic c80_reg;
  logic [2:0] mode_reg;
  logic [7:0] cyc_reg;
  logic [2:0] mode_next;
  logic [7:0] cyc_next;
  logic [2:0] cap;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] free;
  logic [2:0] slack;
  logic push;
  logic pop;

  // pin is asynchronous to clk; reset to the pull-up level so an early
  // sample reads as 40-conductor, the safe answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cblid_meta_reg <= 1'b1;
      cblid_sync_reg <= 1'b1;
    end else begin
      cblid_meta_reg <= cblid_pin;
      cblid_sync_reg <= cblid_meta_reg;
    end
  end

  // detection: wait for the line to settle, then sample it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= UDQ_IDLE;
      timer_reg <= '0;
      known_reg <= 1'b0;
      c80_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        UDQ_IDLE, UDQ_DONE: begin
          if (detect_start && !use_identify) begin
            state_reg <= UDQ_SETTLE;
            timer_reg <= TW'(SETTLE_CYC - 1);
            known_reg <= 1'b0;
            c80_reg <= 1'b0;
          end else if (use_identify && identify_valid) begin
            // drive already discharged and sampled the line
            state_reg <= UDQ_DONE;
            known_reg <= 1'b1;
            c80_reg <= identify_cable80;
          end
        end
        UDQ_SETTLE: begin
          if (timer_reg == '0) begin
            state_reg <= UDQ_DONE;
            known_reg <= 1'b1;
            c80_reg <= ~cblid_sync_reg;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= UDQ_IDLE;
        end
      endcase
    end
  end

  // independent count of settle cycles, so the length check does not reuse the timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_len_reg <= '0;
    end else if (state_reg == UDQ_SETTLE) begin
      settle_len_reg <= settle_len_reg + 1'b1;
    end else begin
      settle_len_reg <= '0;
    end
  end

  // mode cap and cycle time lookup
  always_comb begin
    cap = (known_reg && c80_reg) ? `UDQ_MODE_FAST_MAX : `UDQ_MODE_SLOW_MAX;
    mode_next = (mode_req > cap) ? cap : mode_req;
    unique case (mode_next)
      3'h0: cyc_next = `UDQ_CYC_M0;
      3'h1: cyc_next = `UDQ_CYC_M1;
      3'h2: cyc_next = `UDQ_CYC_M2;
      3'h3: cyc_next = `UDQ_CYC_M3;
      default: cyc_next = `UDQ_CYC_M4;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 3'h0;
      cyc_reg <= `UDQ_CYC_M0;
    end else begin
      mode_reg <= mode_next;
      cyc_reg <= cyc_next;
    end
  end

  assign status = '{cable_known: known_reg, cable80: c80_reg, mode: mode_reg,
                    cycle_ns: cyc_reg};

  // receive buffer: ready drops while room for the in-flight words remains
  assign slack = (mode_reg > `UDQ_MODE_SLOW_MAX) ? `UDQ_SLACK_FAST : `UDQ_SLACK_SLOW;
  assign free = CW'(DEPTH) - cnt_reg;
  assign dmardy = free > CW'(slack);
  assign in_ready = cnt_reg != CW'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  sequence s_ready_drop;
    $fell(dmardy);
  endsequence

  AST_SLOW_SLACK: assert property (@(posedge clk) disable iff (!rst_n)
    s_ready_drop ##0 (mode_reg <= `UDQ_MODE_SLOW_MAX) |-> free >= CW'(`UDQ_SLACK_SLOW))
    else $error("slow mode ready dropped with under two free slots");
  AST_FAST_SLACK: assert property (@(posedge clk) disable iff (!rst_n)
    s_ready_drop ##0 (mode_reg > `UDQ_MODE_SLOW_MAX) |-> free >= CW'(`UDQ_SLACK_FAST))
    else $error("fast mode ready dropped with under three free slots");
  AST_FAST_NEEDS_80: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg > `UDQ_MODE_SLOW_MAX |-> $past(known_reg && c80_reg))
    else $error("fast mode granted without an 80-conductor cable");
  AST_LOW_IS_80: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == UDQ_SETTLE && timer_reg == '0 && !cblid_sync_reg) |=> c80_reg && known_reg)
    else $error("grounded cable-identify not taken as 80-conductor");
  AST_HIGH_IS_40: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == UDQ_SETTLE && timer_reg == '0 && cblid_sync_reg) |=> !c80_reg && known_reg)
    else $error("pulled-up cable-identify not taken as 40-conductor");
  AST_IDENT_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg != UDQ_SETTLE && use_identify && identify_valid) |=>
    known_reg && c80_reg == $past(identify_cable80))
    else $error("identify cable result not captured");
  AST_CAP_TWO: assert property (@(posedge clk) disable iff (!rst_n)
    !(known_reg && c80_reg) |=> mode_reg <= `UDQ_MODE_SLOW_MAX)
    else $error("mode above two without 80-conductor result");
  AST_CYCLE_TIME: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == `UDQ_MODE_FAST_MAX |-> cyc_reg == `UDQ_CYC_M4)
    else $error("mode 4 cycle time wrong");
  AST_SETTLE_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == UDQ_SETTLE && timer_reg == '0) |-> settle_len_reg == TW'(SETTLE_CYC - 1))
    else $error("settle window length wrong");
  AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_reg == CW'(DEPTH) |-> !dmardy ##1 cnt_reg <= CW'(DEPTH))
    else $error("buffer overflow");
endmodule : udq_cable_qual
`default_nettype wire

// >>> udq_drive_model.sv
// udq_drive_model.sv: behavioural drive answering identify with its cable test.
// assumes identify_cmd is a one-cycle pulse driven at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module udq_drive_model (
  input wire logic clk,
  input wire logic identify_cmd,
  input wire logic cable80_fitted,
  output logic identify_valid,
  output logic identify_cable80
);
  logic line = 1'b1;
  logic result = 1'b0;
  initial identify_valid = 1'b0;
  initial identify_cable80 = 1'b0;
  always @(posedge identify_cmd) begin
    line = 1'b0;
    repeat (3) @(posedge clk);
    // open at the drive on 80-cond, so pull-up wins; 40-cond still low
    line = cable80_fitted;
    result = line;
    @(negedge clk);
    identify_cable80 = result;
    identify_valid = 1'b1;
    @(negedge clk);
    identify_valid = 1'b0;
    identify_cable80 = ~result;
  end
endmodule : udq_drive_model
`default_nettype wire

// >>> udq_cable_qual_tb.sv
// udq_cable_qual_tb.sv: self-checking bench for the cable qualification block.
// assumes udq_pkg and udq_drive_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module udq_cable_qual_tb;
  import udq_pkg::*;
  logic clk = 0, rst_n = 0, cblid_pin = 1, detect_start = 0, use_identify = 0;
  logic identify_cmd = 0, fitted = 0, identify_valid, identify_cable80;
  logic in_valid = 0, out_ready = 0, in_ready, dmardy, out_valid;
  logic [2:0] mode_req = 0;
  logic [15:0] in_data = 0, out_data;
  logic [7:0] cyc [5] = '{8'hEB, 8'hA0, 8'h78, 8'h5A, 8'h3C};
  udq_status_t status;
  int errors = 0, checked = 0;
  logic [15:0] exp_q [$];
  always #20 clk = ~clk;
  udq_cable_qual #(.WIDTH(16), .DEPTH(4), .SETTLE_CYC(2)) i_dut (.clk(clk), .rst_n(rst_n),
    .cblid_pin(cblid_pin), .detect_start(detect_start), .use_identify(use_identify),
    .identify_valid(identify_valid), .identify_cable80(identify_cable80), .mode_req(mode_req),
    .status(status), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .dmardy(dmardy), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  udq_drive_model i_drive (.clk(clk), .identify_cmd(identify_cmd), .cable80_fitted(fitted),
    .identify_valid(identify_valid), .identify_cable80(identify_cable80));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() > 0) check(out_data, exp_q.pop_front());
      else check(16'(exp_q.size()), 16'h0001);
    end
  end
  task detect(input logic pin);
    cblid_pin = pin;
    repeat (4) @(negedge clk);
    detect_start = 1;
    @(negedge clk);
    detect_start = 0;
    for (int i = 0; i < 20 && status.cable_known !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : detect
  task modes(input int cap);
    int e;
    for (int m = 0; m < 8; m++) begin
      mode_req = 3'(m);
      repeat (2) @(negedge clk);
      e = (m > cap) ? cap : m;
      check(16'(status.mode), 16'(e));
      check(16'(status.cycle_ns), 16'(cyc[e]));
    end
  endtask : modes
  task burst(input int slack);
    int late;
    late = 0;
    while (in_ready === 1'b1) begin
      if (dmardy !== 1'b1) late++;
      in_valid = 1;
      in_data = 16'($urandom);
      exp_q.push_back(in_data);
      @(negedge clk);
    end
    in_valid = 0;
    check(16'(exp_q.size()), 16'h0004);
    check(16'(late), 16'(slack));
    for (int i = 0; i < 80 && exp_q.size() > 0; i++) begin
      out_ready = 1'($urandom);
      @(negedge clk);
    end
    out_ready = 0;
    @(negedge clk);
    check(16'(out_valid), 16'h0000);
  endtask : burst
  task ident(input logic f);
    fitted = f;
    use_identify = 1;
    identify_cmd = 1;
    @(negedge clk);
    identify_cmd = 0;
    for (int i = 0; i < 20 && identify_valid !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    check(16'(status.cable80), 16'(f));
    modes(f ? 4 : 2);
    use_identify = 0;
  endtask : ident
  initial begin
    #(40 * 4000);
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(21));
    repeat (3) @(negedge clk);
    check(16'(status), 16'h00EB);
    rst_n = 1;
    detect(1'b0);
    check(16'(status.cable80), 16'h0001);
    modes(4);
    burst(3);
    detect(1'b1);
    check(16'(status.cable80), 16'h0000);
    modes(2);
    burst(2);
    ident(1'b1);
    ident(1'b0);
    final_report();
  end
endmodule : udq_cable_qual_tb
`default_nettype wire
